// *** design/codec_port_defs.vh ***
// Register map, field layout, reset values and codes of the control port
`ifndef CODEC_PORT_DEFS_VH
`define CODEC_PORT_DEFS_VH
// Register offsets
`define ADDR_PATH_GAIN    4'h0
`define ADDR_SIDETONE     4'h1
`define ADDR_QUIET        4'h3
`define ADDR_CODING       4'h4
`define ADDR_SIGNALLING   4'h6
// Reset values
`define RST_PATH_GAIN     8'h00
`define RST_SIDETONE      8'h00
`define RST_QUIET         8'h00
`define RST_CODING        8'h00
`define RST_SIGNALLING    8'hFF
// Path gain register fields
`define TXFG_LO           0
`define TXFG_HI           2
`define RXFG_LO           3
`define RXFG_HI           5
`define MIC_BIT           6
`define SPK_LO_BIT        7
// Side-tone register fields
`define STG_LO            0
`define STG_HI            2
`define SPK_HI_BIT        3
`define STG_OFF           3'h0
// Quiet register fields
`define RXQ_BIT           0
`define TXQ_BIT           1
// Coding register fields
`define ALAW_BIT          0
`define SMAG_BIT          1
`define MODE_LO           2
`define MODE_HI           4
`define DEN_BIT           5
`define MODE_TDM          3'h7
// Command byte layout per framing
`define CMD_RW_MSBF       7
`define CMD_AD_MSBF       0
`define CMD_RW_LSBF       0
`define CMD_AD_LSBF       4
// Transfer length and interrupt frame count
`define BITS_CMD          5'h08
`define BITS_ALL          5'h10
`define IRQ_FRAMES        2'h3
// Code table: sign-magnitude, mu-law, A-law
`define SM_PFS            8'hFF
`define SM_PZ             8'h80
`define SM_NZ             8'h00
`define SM_NFS            8'h7F
`define MU_PFS            8'h80
`define MU_PZ             8'hFF
`define MU_NZ             8'h7F
`define MU_NFS            8'h00
`define AL_PFS            8'hAA
`define AL_PZ             8'hD5
`define AL_NZ             8'h55
`define AL_NFS            8'h2A
`endif

// *** design/codec_control_port.v ***
// Serial control port and configuration registers of the filter/codec
`include "codec_port_defs.vh"

module codec_control_port (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Serial port pins
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       bidir_serial_pin_in,
  output reg        bidir_serial_pin_out,
  output reg        bidir_serial_pin_oe_n,
  input  wire       host_to_device_pin,
  // Open-drain interrupt
  output wire       irq_out,
  output reg        irq_oe_n,
  // Frame pulse and law pin
  input  wire       frame_pulse_n,
  input  wire       law_select_pin,
  // Sample paths
  input  wire [7:0] tx_pcm_in,
  input  wire [7:0] rx_pcm_in,
  output reg  [7:0] tx_pcm_out,
  output reg  [7:0] rx_pcm_out,
  // Code table
  output reg  [7:0] pos_full_code,
  output reg  [7:0] pos_zero_code,
  output reg  [7:0] neg_zero_code,
  output reg  [7:0] neg_full_code,
  // Configuration
  output reg  [2:0] tx_filter_gain_field,
  output reg  [2:0] rx_filter_gain_field,
  output reg        mic_amp_gain_select,
  output reg  [1:0] speaker_gain_select,
  output reg  [2:0] sidetone_gain_field,
  output reg        sidetone_enable,
  output reg        a_law_active,
  output reg        code_assignment_select,
  output reg  [2:0] interface_mode,
  output reg        receive_quiet_force,
  output reg        transmit_quiet_force
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CMD  = 3'b010;
  localparam ST_DATA = 3'b100;

  reg [2:0] cs_sync;
  reg [2:0] sclk_sync;
  reg [1:0] d1_sync;
  reg [1:0] d2_sync;
  reg [2:0] fp_sync;
  reg [1:0] law_sync;

  reg [2:0] state;
  reg       lsb_mode;
  reg [4:0] bit_count;
  reg [7:0] cmd_shift;
  reg [7:0] data_shift;
  reg [7:0] out_shift;
  reg       is_read;
  reg [3:0] addr;

  reg [7:0] path_gain_control;
  reg [7:0] sidetone_gain_control;
  reg [7:0] quiet_control;
  reg [7:0] coding_interface_control;
  reg [7:0] signalling_data;

  reg [1:0] frame_count;
  reg       irq_pending;

  wire cs_s      = cs_sync[1];
  wire cs_prev   = cs_sync[2];
  wire sclk_s    = sclk_sync[1];
  wire sclk_prev = sclk_sync[2];
  wire cs_fall   = cs_prev & ~cs_s;
  wire cs_rise   = ~cs_prev & cs_s;
  wire sclk_rise = ~sclk_prev & sclk_s;
  wire sclk_fall = sclk_prev & ~sclk_s;
  wire fp_fall   = fp_sync[2] & ~fp_sync[1];
  // Second pin is ignored in LSB-first framing
  wire in_bit    = lsb_mode ? d1_sync[1] : d2_sync[1];

  // Command byte as seen after the 8th bit
  wire [7:0] cmd_next = lsb_mode ? {in_bit, cmd_shift[7:1]}
                                 : {cmd_shift[6:0], in_bit};
  wire [7:0] dat_next = lsb_mode ? {in_bit, data_shift[7:1]}
                                 : {data_shift[6:0], in_bit};
  wire       cmd_rw   = lsb_mode ? cmd_next[`CMD_RW_LSBF]
                                 : cmd_next[`CMD_RW_MSBF];
  wire [3:0] cmd_addr = lsb_mode ? cmd_next[`CMD_AD_LSBF +: 4]
                                 : cmd_next[`CMD_AD_MSBF +: 4];

  wire tdm_mode = (interface_mode == `MODE_TDM);

  reg [7:0] read_value;
  always @* begin
    case (cmd_addr)
      `ADDR_PATH_GAIN:  read_value = path_gain_control;
      `ADDR_SIDETONE:   read_value = sidetone_gain_control;
      `ADDR_QUIET:      read_value = quiet_control;
      `ADDR_CODING:     read_value = coding_interface_control;
      `ADDR_SIGNALLING: read_value = signalling_data;
      default:          read_value = 8'h00;
    endcase
  end

  // Two stages before any logic; the third stage only feeds edge finding
  always @(posedge clk) begin
    if (rst) begin
      cs_sync   <= 3'h7;
      sclk_sync <= 3'h0;
      d1_sync   <= 2'h0;
      d2_sync   <= 2'h0;
      fp_sync   <= 3'h7;
      law_sync  <= 2'h0;
    end else begin
      cs_sync   <= {cs_sync[1:0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      d1_sync   <= {d1_sync[0], bidir_serial_pin_in};
      d2_sync   <= {d2_sync[0], host_to_device_pin};
      fp_sync   <= {fp_sync[1:0], frame_pulse_n};
      law_sync  <= {law_sync[0], law_select_pin};
    end
  end

  // Clock level at select sets framing; any select rise aborts
  always @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      lsb_mode   <= 1'b0;
      bit_count  <= 5'h00;
      cmd_shift  <= 8'h00;
      data_shift <= 8'h00;
      is_read    <= 1'b0;
      addr       <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cs_fall) begin
            lsb_mode  <= sclk_s;
            bit_count <= 5'h00;
            state     <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cs_s) begin
            state <= ST_IDLE;
          end else if (sclk_rise) begin
            cmd_shift <= cmd_next;
            bit_count <= bit_count + 5'h01;
            if (bit_count == `BITS_CMD - 5'h01) begin
              is_read <= cmd_rw;
              addr    <= cmd_addr;
              state   <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (cs_s) begin
            state <= ST_IDLE;
          end else if (sclk_rise) begin
            data_shift <= dat_next;
            bit_count  <= bit_count + 5'h01;
            if (bit_count == `BITS_ALL - 5'h01) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire write_done = (state == ST_DATA) && !cs_s && sclk_rise &&
                    (bit_count == `BITS_ALL - 5'h01) && !is_read;
  wire read_done  = (state == ST_DATA) && !cs_s && sclk_rise &&
                    (bit_count == `BITS_ALL - 5'h01) && is_read;
  wire cmd_done   = (state == ST_CMD) && !cs_s && sclk_rise &&
                    (bit_count == `BITS_CMD - 5'h01);

  // Read data leaves on falling edges; writes never drive the pin
  always @(posedge clk) begin
    if (rst) begin
      out_shift             <= 8'h00;
      bidir_serial_pin_out  <= 1'b0;
      bidir_serial_pin_oe_n <= 1'b1;
    end else if (cs_s || state == ST_IDLE) begin
      bidir_serial_pin_oe_n <= 1'b1;
    end else if (cmd_done) begin
      out_shift <= read_value;
    end else if (state == ST_DATA && is_read && sclk_fall) begin
      bidir_serial_pin_oe_n <= 1'b0;
      if (lsb_mode) begin
        bidir_serial_pin_out <= out_shift[0];
        out_shift            <= {1'b0, out_shift[7:1]};
      end else begin
        bidir_serial_pin_out <= out_shift[7];
        out_shift            <= {out_shift[6:0], 1'b0};
      end
    end
  end

  // Only a completed write updates a register; read input is ignored
  always @(posedge clk) begin
    if (rst) begin
      path_gain_control        <= `RST_PATH_GAIN;
      sidetone_gain_control    <= `RST_SIDETONE;
      quiet_control            <= `RST_QUIET;
      coding_interface_control <= `RST_CODING;
      signalling_data          <= `RST_SIGNALLING;
    end else if (write_done) begin
      case (addr)
        `ADDR_PATH_GAIN:  path_gain_control        <= dat_next;
        `ADDR_SIDETONE:   sidetone_gain_control    <= dat_next;
        `ADDR_QUIET:      quiet_control            <= dat_next;
        `ADDR_CODING:     coding_interface_control <= dat_next;
        `ADDR_SIGNALLING: signalling_data          <= dat_next;
        default:          signalling_data          <= signalling_data;
      endcase
    end
  end

  // Configuration outputs, registered so they never glitch
  always @(posedge clk) begin
    if (rst) begin
      tx_filter_gain_field   <= 3'h0;
      rx_filter_gain_field   <= 3'h0;
      mic_amp_gain_select    <= 1'b0;
      speaker_gain_select    <= 2'h0;
      sidetone_gain_field    <= `STG_OFF;
      sidetone_enable        <= 1'b0;
      a_law_active           <= 1'b0;
      code_assignment_select <= 1'b0;
      interface_mode         <= 3'h0;
      receive_quiet_force    <= 1'b0;
      transmit_quiet_force   <= 1'b0;
    end else begin
      tx_filter_gain_field <=
        path_gain_control[`TXFG_HI:`TXFG_LO];
      rx_filter_gain_field <=
        path_gain_control[`RXFG_HI:`RXFG_LO];
      mic_amp_gain_select  <= path_gain_control[`MIC_BIT];
      // Codes 2 and 3 both mean -12 dB
      speaker_gain_select  <= {sidetone_gain_control[`SPK_HI_BIT],
                               path_gain_control[`SPK_LO_BIT]};
      sidetone_gain_field  <=
        sidetone_gain_control[`STG_HI:`STG_LO];
      sidetone_enable      <= sidetone_gain_control[`STG_HI:`STG_LO]
                              != `STG_OFF;
      a_law_active         <= coding_interface_control[`ALAW_BIT] |
                              law_sync[1];
      code_assignment_select <=
        coding_interface_control[`SMAG_BIT];
      interface_mode       <= coding_interface_control[`MODE_HI:`MODE_LO];
      receive_quiet_force  <= quiet_control[`RXQ_BIT];
      transmit_quiet_force <= quiet_control[`TXQ_BIT];
    end
  end

  // Code table lookup by kind: 0 +FS, 1 +0, 2 -0, 3 -FS
  function [7:0] code_of;
    input [1:0] kind;
    input       alaw;
    input       smag;
    reg   [7:0] sm;
    reg   [7:0] mu;
    reg   [7:0] al;
    begin
      case (kind)
        2'h0:    begin sm = `SM_PFS; mu = `MU_PFS; al = `AL_PFS; end
        2'h1:    begin sm = `SM_PZ;  mu = `MU_PZ;  al = `AL_PZ;  end
        2'h2:    begin sm = `SM_NZ;  mu = `MU_NZ;  al = `AL_NZ;  end
        default: begin sm = `SM_NFS; mu = `MU_NFS; al = `AL_NFS; end
      endcase
      code_of = smag ? sm : (alaw ? al : mu);
    end
  endfunction

  wire [31:0] codes;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_code
      localparam [31:0] KIND = k;
      assign codes[8*k +: 8] = code_of(KIND[1:0], a_law_active,
                                       code_assignment_select);
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      pos_full_code <= `MU_PFS;
      pos_zero_code <= `MU_PZ;
      neg_zero_code <= `MU_NZ;
      neg_full_code <= `MU_NFS;
      tx_pcm_out    <= `MU_NZ;
      rx_pcm_out    <= `MU_NZ;
    end else begin
      pos_full_code <= codes[7:0];
      pos_zero_code <= codes[15:8];
      neg_zero_code <= codes[23:16];
      neg_full_code <= codes[31:24];
      tx_pcm_out <= transmit_quiet_force ? codes[23:16]
                                         : tx_pcm_in;
      rx_pcm_out <= receive_quiet_force ? codes[23:16]
                                        : rx_pcm_in;
    end
  end

  // In TDM mode every fourth frame raises the interrupt; a signalling access or the next frame drops it
  wire sig_access = (write_done || read_done) &&
                    (addr == `ADDR_SIGNALLING);
  wire irq_set    = tdm_mode && fp_fall && (frame_count == `IRQ_FRAMES);
  always @(posedge clk) begin
    if (rst) begin
      frame_count <= 2'h0;
      irq_pending <= 1'b0;
      irq_oe_n    <= 1'b1;
    end else begin
      if (fp_fall) begin
        frame_count <= frame_count + 2'h1;
      end
      // A new pacing event beats a clear in the same cycle
      if (irq_set) begin
        irq_pending <= 1'b1;
      end else if (sig_access || fp_fall || !tdm_mode) begin
        irq_pending <= 1'b0;
      end
      irq_oe_n <= ~(irq_pending && tdm_mode &&
                    coding_interface_control[`DEN_BIT]);
    end
  end

  // Open drain: only ever pulls low
  assign irq_out = 1'b0;

endmodule

// *** test/port_checker_sva.sv ***
// Assertions on the control port pins and configuration outputs
module port_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Serial, interrupt and law pins
  input wire logic       cs_n,
  input wire logic       bidir_serial_pin_oe_n,
  input wire logic       irq_oe_n,
  input wire logic       law_select_pin,
  // Configuration and sample paths
  input wire logic [2:0] interface_mode,
  input wire logic [2:0] sidetone_gain_field,
  input wire logic       sidetone_enable,
  input wire logic       a_law_active,
  input wire logic       code_assignment_select,
  input wire logic       receive_quiet_force,
  input wire logic       transmit_quiet_force,
  input wire logic [7:0] tx_pcm_in,
  input wire logic [7:0] tx_pcm_out,
  input wire logic [7:0] rx_pcm_out,
  input wire logic [7:0] pos_full_code,
  input wire logic [7:0] pos_zero_code,
  input wire logic [7:0] neg_zero_code,
  input wire logic [7:0] neg_full_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [31:0] codes = {pos_full_code, pos_zero_code, neg_zero_code,
                       neg_full_code};
  a_oe_release: assert property
    (cs_n [*5] |-> bidir_serial_pin_oe_n)
    else $error("data pin driven while deselected");
  a_sidetone_off: assert property
    (sidetone_enable == (sidetone_gain_field != 3'h0))
    else $error("side-tone enable disagrees with gain field");
  a_law_pin: assert property
    (law_select_pin [*5] |-> a_law_active)
    else $error("law pin did not force A-law");
  a_smag_codes: assert property
    (code_assignment_select [*2] |-> codes == 32'hFF80007F)
    else $error("sign-magnitude code table wrong");
  a_mu_codes: assert property
    ((!code_assignment_select && !a_law_active) [*2]
      |-> codes == 32'h80FF7F00)
    else $error("mu-law code table wrong");
  a_alaw_codes: assert property
    ((!code_assignment_select && a_law_active) [*2]
      |-> codes == 32'hAAD5552A)
    else $error("A-law code table wrong");
  a_rx_quiet: assert property
    (receive_quiet_force [*2] ##0 $stable(neg_zero_code)
      |-> rx_pcm_out == neg_zero_code)
    else $error("receive path not quiet");
  a_tx_pass: assert property
    ((!transmit_quiet_force) [*2] ##0 !$past(rst)
      |-> tx_pcm_out == $past(tx_pcm_in))
    else $error("transmit path altered while not forced");
  a_irq_mode: assert property
    ((interface_mode != 3'h7) [*3] |-> irq_oe_n)
    else $error("interrupt outside frame mode");
  c_read: cover property (!bidir_serial_pin_oe_n);
  c_irq: cover property (!irq_oe_n);
  c_alaw: cover property (a_law_active && !code_assignment_select);
endmodule

bind codec_control_port port_checker u_chk (.*);

// *** test/host_mcu_model.sv ***
// Host controller model driving the two-byte serial control transfers
module host_mcu_model (
  // Clock
  input wire logic  clk,
  // Serial pins
  output logic      cs_n = 1'b1,
  output logic      sclk = 1'b0,
  output logic      host_to_device_pin = 1'b0,
  output wire logic bidir_serial_pin_in,
  input wire logic  bidir_serial_pin_out,
  input wire logic  bidir_serial_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hdrv = 1'b0;
  logic hval = 1'b0;
  logic last = 1'b0;
  // Released wire has no pull: show a changing level, never a stale one
  assign bidir_serial_pin_in = !bidir_serial_pin_oe_n ? bidir_serial_pin_out :
                               hdrv ? hval : ~last;
  always @(posedge clk) begin
    last <= bidir_serial_pin_in;
  end
  task automatic xfer(input bit lsb, input logic [7:0] cmd, dat,
                      input int n, output logic [7:0] rd);
    logic [15:0] w;
    bit          rw;
    w = lsb ? {dat, cmd} : {cmd, dat};
    rw = lsb ? cmd[0] : cmd[7];
    rd = 8'h00;
    @(posedge clk) sclk <= lsb;
    repeat (4) @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      hdrv <= lsb && !(rw && i > 7);
      hval <= lsb ? w[i] : w[15-i];
      host_to_device_pin <= (rw && i > 7) ? 1'($urandom % 2)
                                          : w[15-i];
      repeat (4) @(posedge clk);
      // Take the bit as the clock rises, one cycle after it settled
      if (i > 7) begin
        rd[lsb ? i-8 : 15-i] = bidir_serial_pin_in;
      end
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'b1;
    hdrv <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** test/serial_microport_codec_control_tb.sv ***
// Self-checking bench for the codec serial control port
module serial_microport_codec_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, fp_n = 1, law = 0;
  logic [7:0] txi = 0, rxi = 0, rd;
  wire cs_n, sclk, d_in, d_out, d_oe_n, h2d, irq_out, irq_oe_n;
  wire [7:0] txo, rxo, pfc, pzc, nzc, nfc;
  wire [2:0] txg, rxg, stg, mode;
  wire [1:0] spk;
  wire mic, sten, alaw, cas, rq, tq;
  int fail_count = 0, comparisons = 0, a, m[16];
  int sel[5] = '{0, 1, 3, 4, 2};
  wire [31:0] got_cfg = {txg, rxg, mic, spk, stg, sten, alaw, cas, mode,
                         rq, tq};
  always #25 clk = ~clk;
  codec_control_port DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .bidir_serial_pin_in(d_in), .bidir_serial_pin_out(d_out),
    .bidir_serial_pin_oe_n(d_oe_n), .host_to_device_pin(h2d),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .frame_pulse_n(fp_n),
    .law_select_pin(law), .tx_pcm_in(txi), .rx_pcm_in(rxi),
    .tx_pcm_out(txo), .rx_pcm_out(rxo), .pos_full_code(pfc),
    .pos_zero_code(pzc), .neg_zero_code(nzc), .neg_full_code(nfc),
    .tx_filter_gain_field(txg), .rx_filter_gain_field(rxg),
    .mic_amp_gain_select(mic), .speaker_gain_select(spk),
    .sidetone_gain_field(stg), .sidetone_enable(sten), .a_law_active(alaw),
    .code_assignment_select(cas), .interface_mode(mode),
    .receive_quiet_force(rq), .transmit_quiet_force(tq));
  host_mcu_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .host_to_device_pin(h2d), .bidir_serial_pin_in(d_in),
    .bidir_serial_pin_out(d_out), .bidir_serial_pin_oe_n(d_oe_n));
  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [31:0] codes();
    if (m[4][1]) return 32'hFF80007F;
    if (m[4][0] | law) return 32'hAAD5552A;
    return 32'h80FF7F00;
  endfunction
  function logic [31:0] cfg();
    return {m[0][2:0], m[0][5:3], m[0][6], m[1][3], m[0][7], m[1][2:0],
            m[1][2:0] != 0, m[4][0] | law, m[4][1], m[4][4:2],
            m[3][0], m[3][1]};
  endfunction
  function logic [7:0] cmd(bit lsb, int ad, bit rw);
    return lsb ? {ad[3:0], 3'h0, rw} : {rw, 3'h0, ad[3:0]};
  endfunction
  function bit mapped(int ad);
    return ad inside {0, 1, 3, 4, 6};
  endfunction
  task wr(input bit lsb, input int ad, d, input int n = 16);
    host.xfer(lsb, cmd(lsb, ad, 0), d[7:0], n, rd);
    if (n == 16 && mapped(ad)) m[ad] = d % 256;
  endtask
  task rdc(input bit lsb, input int ad);
    host.xfer(lsb, cmd(lsb, ad, 1), 8'($urandom), 16, rd);
    chk(rd, mapped(ad) ? m[ad] % 256 : 0);
  endtask
  task check();
    logic [31:0] c;
    txi <= 8'($urandom);
    rxi <= 8'($urandom);
    repeat (3) @(posedge clk);
    c = codes();
    chk(got_cfg, cfg());
    chk(got_codes(), c);
    chk({rxo, txo}, {m[3][0] ? c[15:8] : rxi,
                     m[3][1] ? c[15:8] : txi});
    chk(irq_out, 0);
  endtask
  function logic [31:0] got_codes();
    return {pfc, pzc, nzc, nfc};
  endfunction
  task conclude();
    $display("mismatches %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(33521));
    foreach (m[i]) m[i] = 0;
    m[6] = 255;
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (8) @(posedge clk);
    chk(got_cfg, cfg());
    chk(got_codes(), 32'h80FF7F00);
    chk({d_oe_n, irq_oe_n}, 2'b11);
    // Alternate framing between write and read-back to exercise both layouts
    for (int i = 0; i < 20; i++) begin
      a = sel[$urandom % 5];
      wr(i % 2, a, $urandom % 256);
      rdc(!(i % 2), a);
      check();
    end
    for (int k = 0; k < 8; k++) begin
      law <= k[2];
      wr(k[0], 4, k % 4);
      check();
    end
    law <= 0;
    wr(0, 0, 8'h5A, 12);
    rdc(1, 0);
    // A read cut short must still let go of the data pin
    host.xfer(1, cmd(1, 0, 1), 8'h00, 12, rd);
    chk(d_oe_n, 1);
    wr(0, 4, 8'h3C);
    for (int p = 0; p < 8 && irq_oe_n !== 1'b0; p++) begin
      fp_n <= 0;
      repeat (4) @(posedge clk);
      fp_n <= 1;
      repeat (8) @(posedge clk);
    end
    chk(irq_oe_n, 0);
    rdc(0, 6);
    repeat (4) @(posedge clk);
    chk(irq_oe_n, 1);
    conclude();
  end
endmodule
